/* hdl/pppoc_top.v */
// Purpose: Downstream port power control and overcurrent sense
// Assumes: APB slave, pins synchronous to pclk
// Notes: Each pin is open drain with a switchable pull-up
//
// Behaviour
// - Ganged and individual port control modes
// - Individual mode after reset
// - Ganged uses shared pin for all ports
// - Ganged overcurrent flags every port
// - Power off drives pin low, pull-up off
// - Power on releases driver, pull-up on
// - Powered port samples pin, low is overcurrent
// - Long low beyond minimum width declares overcurrent
// - Two low groups within window declare
// - Lockout after power on ignores pin
// - Minimum width 4 bits, reset 5 ms
// - Window 8 bits, reset 20 ms
// - Lockout 8 bits, reset 10 ms
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "pppoc_defines.vh"

module pppoc_top #(
    parameter TICK_CYCLES = `PPPOC_CLK_KHZ * `PPPOC_TICK_MS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [5:0] port_power_sense_pin_i,
    output wire [5:0] port_power_sense_pin_o,
    output wire [5:0] port_power_sense_pin_oe,
    output wire [5:0] port_pullup_en,
    input wire shared_power_sense_pin_i,
    output wire shared_power_sense_pin_o,
    output wire shared_power_sense_pin_oe,
    output wire shared_pullup_en,
    output wire irq
);
    reg [7:0] lockout_r;
    reg [7:0] lockout_nxt;
    reg [3:0] min_width_r;
    reg [3:0] min_width_nxt;
    reg [7:0] window_r;
    reg [7:0] window_nxt;
    reg gang_r;
    reg gang_nxt;
    reg [5:0] pwr_r;
    reg [5:0] pwr_nxt;
    reg [5:0] stat_r;
    reg [5:0] stat_nxt;
    reg [5:0] mask_r;
    reg [5:0] mask_nxt;
    reg [16:0] tick_cnt_r;
    reg [16:0] tick_cnt_nxt;
    reg tick_r;
    reg tick_nxt;
    reg [31:0] rd_nxt;
    reg hit;
    wire [13:0] idx;
    wire [15:0] reg_sel;
    wire setup;
    wire access;
    wire wr;
    wire wr_ok;
    wire wr_lockout;
    wire wr_minw;
    wire wr_window;
    wire wr_ctrl;
    wire wr_pwr;
    wire wr_stat;
    wire wr_mask;
    wire [16:0] tick_last;
    wire [5:0] oc_evt;
    wire [5:0] oc_set;
    wire [5:0] port_on;
    wire gang_on;

    assign idx = paddr[15:2];
    assign reg_sel = {2'b00, idx};
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign pready = 1'b1;

    // Address decode and read mux
    always @* begin
        hit = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (reg_sel)
            `PPPOC_IDX_LOCKOUT: begin
                rd_nxt[7:0] = lockout_r;
            end
            `PPPOC_IDX_MINW: begin
                rd_nxt[3:0] = min_width_r;
            end
            `PPPOC_IDX_WINDOW: begin
                rd_nxt[7:0] = window_r;
            end
            `PPPOC_IDX_CTRL: begin
                rd_nxt[`PPPOC_CTRL_GANG_BIT] = gang_r;
            end
            `PPPOC_IDX_PWR: begin
                rd_nxt[5:0] = pwr_r;
            end
            `PPPOC_IDX_STAT: begin
                rd_nxt[5:0] = stat_r;
            end
            `PPPOC_IDX_MASK: begin
                rd_nxt[5:0] = mask_r;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Unmapped or misaligned access is refused
    assign pslverr = access && (!hit || paddr[1:0] != 2'b00);
    assign wr_ok = wr && !pslverr;

    // Read data loaded in setup, held through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rd_nxt;
        end
    end

    // Write strobes per register
    assign wr_lockout = wr_ok && (reg_sel == `PPPOC_IDX_LOCKOUT);
    assign wr_minw = wr_ok && (reg_sel == `PPPOC_IDX_MINW);
    assign wr_window = wr_ok && (reg_sel == `PPPOC_IDX_WINDOW);
    assign wr_ctrl = wr_ok && (reg_sel == `PPPOC_IDX_CTRL);
    assign wr_pwr = wr_ok && (reg_sel == `PPPOC_IDX_PWR);
    assign wr_stat = wr_ok && (reg_sel == `PPPOC_IDX_STAT);
    assign wr_mask = wr_ok && (reg_sel == `PPPOC_IDX_MASK);

    // Next values of the configuration registers
    always @* begin
        lockout_nxt = lockout_r;
        min_width_nxt = min_width_r;
        window_nxt = window_r;
        gang_nxt = gang_r;
        pwr_nxt = pwr_r;
        mask_nxt = mask_r;
        if (wr_lockout) begin
            lockout_nxt = pwdata[7:0];
        end
        if (wr_minw) begin
            min_width_nxt = pwdata[`PPPOC_MINW_MSB:0];
        end
        if (wr_window) begin
            window_nxt = pwdata[7:0];
        end
        if (wr_ctrl) begin
            gang_nxt = pwdata[`PPPOC_CTRL_GANG_BIT];
        end
        if (wr_pwr) begin
            pwr_nxt = pwdata[5:0];
        end
        if (wr_mask) begin
            mask_nxt = pwdata[5:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lockout_r <= `PPPOC_RST_LOCKOUT;
        end else begin
            lockout_r <= lockout_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_width_r <= `PPPOC_RST_MINW;
        end else begin
            min_width_r <= min_width_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_r <= `PPPOC_RST_WINDOW;
        end else begin
            window_r <= window_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gang_r <= 1'b0;
        end else begin
            gang_r <= gang_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_r <= 6'h00;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 6'h00;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // Millisecond tick, free running
    assign tick_last = TICK_CYCLES[16:0] - 17'h00001;

    always @* begin
        tick_cnt_nxt = tick_cnt_r + 17'h00001;
        tick_nxt = 1'b0;
        if (tick_cnt_r == tick_last) begin
            tick_cnt_nxt = 17'h00000;
            tick_nxt = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // Shared pin is powered when ganged and any port is on
    assign gang_on = gang_r && (pwr_r != 6'h00);
    assign shared_power_sense_pin_o = 1'b0;
    assign shared_power_sense_pin_oe = !gang_on;
    assign shared_pullup_en = gang_on;

    // Per-port pin drive and overcurrent filter
    genvar g;
    generate
        for (g = 0; g < `PPPOC_NPORT; g = g + 1) begin : g_port
            wire pwr_g;
            wire pin_g;
            assign port_on[g] = !gang_r && pwr_r[g];
            assign port_power_sense_pin_o[g] = 1'b0;
            assign port_power_sense_pin_oe[g] = !port_on[g];
            assign port_pullup_en[g] = port_on[g];
            if (g == 0) begin : g_first
                // Port 0 filter serves the shared pin when ganged
                assign pwr_g = gang_r ? gang_on : port_on[0];
                assign pin_g = gang_r ? shared_power_sense_pin_i : port_power_sense_pin_i[0];
            end else begin : g_rest
                assign pwr_g = port_on[g];
                assign pin_g = port_power_sense_pin_i[g];
            end
            pppoc_detect u_det (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick_r),
                .powered(pwr_g),
                .pin_in(pin_g),
                .min_width(min_width_r),
                .window(window_r),
                .lockout(lockout_r),
                .oc_evt(oc_evt[g])
            );
        end
    endgenerate

    assign oc_set = gang_r ? {6{oc_evt[0]}} : oc_evt;

    // Sticky status, write one to clear, set wins
    always @* begin
        stat_nxt = stat_r;
        if (wr_stat) begin
            stat_nxt = stat_r & ~pwdata[5:0];
        end
        stat_nxt = stat_nxt | oc_set;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 6'h00;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Level interrupt while an unmasked status bit is set
    assign irq = |(stat_r & mask_r);
endmodule // pppoc_top

/* hdl/pppoc_defines.vh */
// Purpose: Constants for port power and overcurrent block
// Assumes: 32-bit APB, byte address = 4 * register index
// Notes: Definitions only
`ifndef PPPOC_DEFINES_VH
`define PPPOC_DEFINES_VH

`define PPPOC_NPORT 6
`define PPPOC_AW 16
// Register indices
`define PPPOC_IDX_LOCKOUT 16'h30e1
`define PPPOC_IDX_MINW 16'h30ea
`define PPPOC_IDX_WINDOW 16'h30eb
`define PPPOC_IDX_CTRL 16'h30f0
`define PPPOC_IDX_PWR 16'h30f1
`define PPPOC_IDX_STAT 16'h30f2
`define PPPOC_IDX_MASK 16'h30f3
// Fields
`define PPPOC_CTRL_GANG_BIT 0
`define PPPOC_MINW_MSB 3
// Reset values
`define PPPOC_RST_LOCKOUT 8'h0a
`define PPPOC_RST_MINW 4'h5
`define PPPOC_RST_WINDOW 8'h14
// Timing
`define PPPOC_CLK_KHZ 100000
`define PPPOC_TICK_MS 1

`endif

/* hdl/pppoc_detect.v */
// Purpose: Overcurrent filter for one port control pin
// Assumes: tick is a one-cycle pulse every 1 ms
// Notes: Pulse on oc_evt when an overcurrent is declared
`timescale 1ns/1ps
`include "pppoc_defines.vh"

module pppoc_detect (
    input wire pclk,
    input wire presetn,
    input wire tick,
    input wire powered,
    input wire pin_in,
    input wire [3:0] min_width,
    input wire [7:0] window,
    input wire [7:0] lockout,
    output reg oc_evt
);
    reg powered_r;
    reg low_r;
    reg tripped_r;
    reg [7:0] lock_cnt_r;
    reg [3:0] low_cnt_r;
    reg [7:0] win_cnt_r;
    wire low_now;
    wire armed;
    wire onset;
    wire single_hit;
    wire double_hit;

    assign low_now = ~pin_in;
    assign armed = powered && powered_r && (lock_cnt_r == 8'h00) && !tripped_r;
    assign onset = armed && low_now && !low_r;
    assign single_hit = armed && low_now && (low_cnt_r >= min_width);
    assign double_hit = onset && (win_cnt_r != 8'h00);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_r <= 1'b0;
            low_r <= 1'b0;
            tripped_r <= 1'b0;
            lock_cnt_r <= 8'h00;
            low_cnt_r <= 4'h0;
            win_cnt_r <= 8'h00;
            oc_evt <= 1'b0;
        end else begin
            powered_r <= powered;
            low_r <= armed && low_now;
            oc_evt <= single_hit || double_hit;
            if (!powered) begin
                tripped_r <= 1'b0;
                lock_cnt_r <= 8'h00;
            end else if (!powered_r) begin
                lock_cnt_r <= lockout;
            end else if (tick && lock_cnt_r != 8'h00) begin
                lock_cnt_r <= lock_cnt_r - 8'h01;
            end else if (single_hit || double_hit) begin
                tripped_r <= 1'b1;
            end
            if (!(armed && low_now)) begin
                low_cnt_r <= 4'h0;
            end else if (tick && low_cnt_r != 4'hf) begin
                low_cnt_r <= low_cnt_r + 4'h1;
            end
            if (!armed) begin
                win_cnt_r <= 8'h00;
            end else if (onset && win_cnt_r == 8'h00) begin
                win_cnt_r <= window;
            end else if (tick && win_cnt_r != 8'h00) begin
                win_cnt_r <= win_cnt_r - 8'h01;
            end
        end
    end
endmodule // pppoc_detect

/* sim/pppoc_monitor.sv */
// Purpose: Port checks for pppoc_top
// Assumes: One pclk domain
// Notes: Bound at the foot
`timescale 1ns/1ps
module pppoc_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire pslverr,
    input wire [5:0] port_power_sense_pin_o,
    input wire [5:0] port_power_sense_pin_oe,
    input wire [5:0] port_pullup_en,
    input wire shared_power_sense_pin_oe,
    input wire shared_pullup_en,
    input wire irq
);
    wire apb_wr = psel && penable && pwrite;
    wire any_on = |port_pullup_en || shared_pullup_en;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_port_drive: assert property (port_power_sense_pin_oe == ~port_pullup_en)
        else $error("pin drive clash");
    chk_open_drain: assert property (port_power_sense_pin_o == 6'h00)
        else $error("pin driven high");
    chk_shared_drive: assert property (shared_power_sense_pin_oe != shared_pullup_en)
        else $error("shared drive clash");
    chk_gang_ports: assert property (shared_pullup_en |-> port_power_sense_pin_oe == 6'h3f)
        else $error("port on when ganged");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    chk_err_align: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned accepted");
    chk_power_cause: assert property ($changed(port_pullup_en) |-> $past(apb_wr))
        else $error("power moved alone");
    chk_irq_cause: assert property ($rose(irq) |-> $past(apb_wr) || $past(any_on, 2))
        else $error("irq without cause");
endmodule // pppoc_monitor
bind pppoc_top pppoc_monitor u_pppoc_monitor (.*);

/* sim/pppoc_switch_model.sv */
// Purpose: Power switch flags on port pins
// Assumes: Bit 6 is the shared pin
// Notes: A fault pulls the flag low
`timescale 1ns/1ps
module pppoc_switch_model (
    input wire [6:0] drive_low,
    input wire [6:0] pull_en,
    input wire [6:0] fault,
    output wire [6:0] level
);
    // Any low driver wins over the pull-up
    // Fault also stands for an opened poly fuse behind a diode
    // Such setups keep power-good delay descriptors at zero
    assign level = ~drive_low & ~fault & pull_en;
endmodule // pppoc_switch_model

/* sim/port_power_overcurrent_tb.sv */
// Purpose: Self-checking bench for pppoc_top
// Assumes: TICK_CYCLES 10, 1 ms is 10 cycles
// Notes: Faults enter through the switch model
`timescale 1ns/1ps
module port_power_overcurrent_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, shared_power_sense_pin_o, shared_power_sense_pin_oe;
    logic shared_pullup_en;
    logic [5:0] port_power_sense_pin_o, port_power_sense_pin_oe, port_pullup_en;
    wire [5:0] port_power_sense_pin_i;
    wire shared_power_sense_pin_i;
    logic [6:0] fault = 7'h0;
    int miscompares = 0, checked = 0, cycles = 0;
    initial forever #5 pclk = ~pclk;
    pppoc_top #(.TICK_CYCLES(10)) u_pppoc_top (.*);
    pppoc_switch_model u_pppoc_switch_model (.fault(fault),
        .drive_low({shared_power_sense_pin_oe, port_power_sense_pin_oe}),
        .pull_en({shared_pullup_en, port_pullup_en}),
        .level({shared_power_sense_pin_i, port_power_sense_pin_i}));
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {8'hc3, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, prdata);
    endtask
    task automatic pulse(input int b, input int pre, input int n);
        repeat (pre) @(posedge pclk);
        fault[b] <= 1'b1;
        repeat (n) @(posedge pclk);
        fault[b] <= 1'b0;
    endtask
    task automatic t_reset;
        rd("lockout", 8'h84, 32'h0a);
        rd("min width", 8'ha8, 32'h05);
        rd("window", 8'hac, 32'h14);
        rd("ctrl", 8'hc0, 32'h0);
        rd("unmapped", 8'hd0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, pslverr});
        chk("pready", 32'h1, {31'h0, pready});
        chk("shared oe", 32'h1, {31'h0, shared_power_sense_pin_oe});
        chk("pin out", 32'h0, {25'h0, shared_power_sense_pin_o, port_power_sense_pin_o});
        $display("reset test done");
    endtask
    task automatic t_single;
        apb(1'b1, 8'h84, 32'h04);
        apb(1'b1, 8'ha8, 32'hf2);
        rd("min width", 8'ha8, 32'h02);
        apb(1'b1, 8'hc4, 32'h01);
        @(posedge pclk);
        chk("pin oe", 32'h3e, {26'h0, port_power_sense_pin_oe});
        pulse(0, 0, 20);
        rd("status lockout", 8'hc8, 32'h0);
        pulse(0, 30, 25);
        rd("status single", 8'hc8, 32'h01);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, 8'hcc, 32'h3f);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, 8'hc8, 32'h01);
        rd("status clear", 8'hc8, 32'h0);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("single test done");
    endtask
    task automatic t_double;
        apb(1'b1, 8'ha8, 32'h0f);
        apb(1'b1, 8'hc4, 32'h02);
        pulse(1, 45, 2);
        pulse(1, 10, 2);
        rd("status double", 8'hc8, 32'h02);
        $display("double test done");
    endtask
    task automatic t_gang;
        apb(1'b1, 8'ha8, 32'h02);
        apb(1'b1, 8'hc0, 32'h01);
        @(posedge pclk);
        chk("gang oe", 32'h3f, {26'h0, port_power_sense_pin_oe});
        chk("gang pullup", 32'h40, {25'h0, shared_pullup_en, port_pullup_en});
        pulse(6, 45, 25);
        rd("status gang", 8'hc8, 32'h3f);
        $display("gang test done");
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_single();
        t_double();
        t_gang();
        complete_run();
    end
    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
endmodule // port_power_overcurrent_tb
